// *** hw/coaal_map.svh ***
// Register offsets, writable-bit masks, reset values and output levels
`ifndef COAAL_MAP_SVH
`define COAAL_MAP_SVH

// Byte offsets within the slave window
`define COAAL_OFF_CTRL      8'h00
`define COAAL_OFF_LIMITS    8'h04
`define COAAL_OFF_FLOW_THR  8'h08
`define COAAL_OFF_CFG0      8'h0C
`define COAAL_OFF_THR0      8'h1C
`define COAAL_OFF_STATUS    8'h2C
`define COAAL_OFF_IRQ_STAT  8'h30
`define COAAL_OFF_IRQ_MASK  8'h34

// Writable bits of the control, channel configuration and interrupt status registers
`define COAAL_CTRL_WMASK    32'h0000_007F
`define COAAL_CFG_WMASK     32'h0000_07FF
`define COAAL_IRQ_WMASK     3'h7

// Reset values
`define COAAL_CTRL_RST      32'h0000_0008
`define COAAL_LIMITS_RST    32'hFFFF_0000
`define COAAL_FLOW_THR_RST  16'h0100
`define COAAL_CFG_ALARM_RST 32'h0000_0000
`define COAAL_CFG_GREEN_RST 32'h0000_07E5
`define COAAL_CFG_BLUE_RST  32'h0000_0385
`define COAAL_CFG_RED_RST   32'h0000_0001
`define COAAL_THR_ALARM_RST 32'h3520_2EE0
`define COAAL_THR_RED_RST   32'h3E80_3A98
`define COAAL_THR_LED_RST   32'hFFFF_0000

// Output levels in microamps
`define COAAL_LVL_MIN       16'h0FA0
`define COAAL_LVL_MAX       16'h4E20
`define COAAL_LVL_MID       16'h2710
`define COAAL_LVL_UNDER     16'h07D0
`define COAAL_LVL_SPAN      32'h0000_3E80

`endif

// *** hw/coaal_pkg.sv ***
// Types shared by the output and alarm logic
package coaal_pkg;

  typedef enum logic [1:0] {
    COAAL_SRC_GAS  = 2'h0,
    COAAL_SRC_ABS  = 2'h1,
    COAAL_SRC_DIFF = 2'h2,
    COAAL_SRC_RSVD = 2'h3
  } coaal_src_e;

  typedef enum logic [2:0] {
    COAAL_FB_MAX   = 3'h0,
    COAAL_FB_MIN   = 3'h1,
    COAAL_FB_UNDER = 3'h2,
    COAAL_FB_CONT  = 3'h3,
    COAAL_FB_LATCH = 3'h4,
    COAAL_FB_R5    = 3'h5,
    COAAL_FB_R6    = 3'h6,
    COAAL_FB_R7    = 3'h7
  } coaal_fb_e;

  typedef enum logic [2:0] {
    COAAL_MODE_OFF     = 3'h0,
    COAAL_MODE_THR     = 3'h1,
    COAAL_MODE_THR_INV = 3'h2,
    COAAL_MODE_IN      = 3'h3,
    COAAL_MODE_IN_INV  = 3'h4,
    COAAL_MODE_PHASE   = 3'h5,
    COAAL_MODE_R6      = 3'h6,
    COAAL_MODE_R7      = 3'h7
  } coaal_mode_e;

  typedef struct packed {
    logic [24:0] rsvd;
    logic        flow_en;
    coaal_fb_e   fallback;
    logic        test;
    coaal_src_e  src;
  } coaal_ctrl_s;

  typedef struct packed {
    logic [15:0] high;
    logic [15:0] low;
  } coaal_limits_s;

  typedef struct packed {
    logic [20:0] rsvd;
    logic [5:0]  phase_mask;
    logic [1:0]  in_sel;
    coaal_mode_e mode;
  } coaal_cfg_s;

  typedef struct packed {
    logic [15:0] upper;
    logic [15:0] lower;
  } coaal_thr_s;

  typedef struct packed {
    logic [15:0] gas;
    logic [15:0] abs_press;
    logic [15:0] diff_press;
  } coaal_meas_s;

endpackage

// *** hw/coaal_chan.sv ***
// One alarm channel: threshold, input-follow or phase-follow driver
module coaal_chan (
  // System
  input  wire logic                clock,
  input  wire logic                reset,
  // Settings
  input  wire coaal_pkg::coaal_cfg_s cfg,
  input  wire coaal_pkg::coaal_thr_s thr,
  // Sources
  input  wire logic [15:0]         level,
  input  wire logic [3:0]          inputs,
  input  wire logic [5:0]          phases,
  // Result
  output logic                     active_q
);

  // Channel state per selected mode
  always_ff @(posedge clock) begin
    if (reset) begin
      active_q <= 1'b0;
    end else begin
      case (cfg.mode)
        coaal_pkg::COAAL_MODE_OFF: begin
          active_q <= 1'b0;
        end
        coaal_pkg::COAAL_MODE_THR: begin
          if (level > thr.upper) begin
            active_q <= 1'b1;
          end else if (level < thr.lower) begin
            active_q <= 1'b0;
          end
        end
        coaal_pkg::COAAL_MODE_THR_INV: begin
          if (level < thr.upper) begin
            active_q <= 1'b1;
          end else if (level > thr.lower) begin
            active_q <= 1'b0;
          end
        end
        coaal_pkg::COAAL_MODE_IN: begin
          active_q <= inputs[cfg.in_sel];
        end
        coaal_pkg::COAAL_MODE_IN_INV: begin
          active_q <= ~inputs[cfg.in_sel];
        end
        coaal_pkg::COAAL_MODE_PHASE: begin
          active_q <= |(phases & cfg.phase_mask);
        end
        default: begin
          active_q <= 1'b0;
        end
      endcase
    end
  end

endmodule

// *** hw/coaal_top.sv ***
// Current-loop output code and alarm/LED drivers with AHB-Lite registers
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`include "coaal_map.svh"

module coaal_top (
  // System
  input  wire logic                 clock,
  input  wire logic                 reset,

  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [31:0]          hwdata,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,

  // Measurements and sequencer state
  input  wire coaal_pkg::coaal_meas_s meas,
  input  wire logic                 sensor_error,
  input  wire logic [5:0]           work_phase,

  // Pins
  input  wire logic [3:0]           digital_inputs_one_to_four,
  input  wire logic                 alarm_pin_i,
  output logic                      alarm_pin_o,
  output logic                      alarm_pin_oe_n,

  // Outputs
  output logic [15:0]               loop_current_level,
  output logic                      led_green,
  output logic                      led_blue,
  output logic                      led_red,
  output logic                      irq
);

  // Phase bit positions
  localparam int PH_STANDBY = 0;
  localparam int PH_WARMUP  = 1;
  localparam int PH_VENT    = 2;
  localparam int PH_MEASURE = 5;
  localparam int NCHAN      = 4;

  // Registers
  coaal_pkg::coaal_ctrl_s   ctrl_q;
  coaal_pkg::coaal_limits_s limits_q;
  logic [15:0]              flow_thr_q;
  coaal_pkg::coaal_cfg_s    cfg_q [NCHAN];
  coaal_pkg::coaal_thr_s    thr_q [NCHAN];
  logic [2:0]               irq_stat_q;
  logic [2:0]               irq_stat_d;
  logic [2:0]               irq_mask_q;

  // Bus state
  logic                     acc;
  logic                     wr_q;
  logic [7:0]               waddr_q;
  logic [31:0]              hrdata_q;
  logic [31:0]              rdata_c;
  logic                     hreadyout_q;

  // Pin synchroniser
  logic [4:0]               pin_s1_q;
  logic [4:0]               pin_s2_q;
  logic [4:0]               pin_s3_q;
  logic [4:0]               pin_q;

  // Datapath
  logic [15:0]              src_value;
  logic [15:0]              live_level;
  logic [15:0]              latch_q;
  logic [15:0]              level_d;
  logic [15:0]              level_q;
  logic                     flow_fault;
  logic                     fault;
  logic                     fb_phase;
  logic                     keep_vent;
  logic [NCHAN-1:0]         chan_state;
  logic                     flow_prev_q;
  logic                     err_prev_q;
  logic                     alarm_prev_q;
  logic [2:0]               events;
  logic [3:0]               led_q;

  // Linear mapping of a reading onto the loop range
  function automatic logic [15:0] scale(
    input logic [15:0] x,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    logic [31:0] num;
    logic [31:0] den;
    num = {16'h0000, 16'(x - lo)} * `COAAL_LVL_SPAN;
    den = {16'h0000, 16'(hi - lo)};
    if (x <= lo) begin
      scale = `COAAL_LVL_MIN;
    end else if (x >= hi) begin
      scale = `COAAL_LVL_MAX;
    end else begin
      scale = 16'(num / den) + `COAAL_LVL_MIN;
    end
  endfunction

  // Fixed level for the configured fallback choice
  function automatic logic [15:0] fixed_level(
    input coaal_pkg::coaal_fb_e fb,
    input logic                 is_fault
  );
    case (fb)
      coaal_pkg::COAAL_FB_MAX:   fixed_level = `COAAL_LVL_MAX;
      coaal_pkg::COAAL_FB_MIN:   fixed_level = `COAAL_LVL_MIN;
      coaal_pkg::COAAL_FB_UNDER: fixed_level = `COAAL_LVL_UNDER;
      default: begin
        fixed_level = is_fault ? `COAAL_LVL_UNDER : `COAAL_LVL_MIN;
      end
    endcase
  endfunction

  // Offset of a per-channel register
  function automatic logic [7:0] chan_off(
    input logic [7:0] base,
    input int         idx
  );
    chan_off = base + 8'(idx * 4);
  endfunction

  // Address phase accepted
  assign acc = hsel & hready & htrans[1];

  // Read data mux on the address-phase address
  always_comb begin
    rdata_c = 32'h0000_0000;
    case (haddr[7:0])
      `COAAL_OFF_CTRL:     rdata_c = ctrl_q;
      `COAAL_OFF_LIMITS:   rdata_c = limits_q;
      `COAAL_OFF_FLOW_THR: rdata_c = {16'h0000, flow_thr_q};
      `COAAL_OFF_STATUS: begin
        rdata_c = {pin_q, flow_fault, work_phase,
                   chan_state, level_q};
      end
      `COAAL_OFF_IRQ_STAT: rdata_c = {29'h0000_0000, irq_stat_q};
      `COAAL_OFF_IRQ_MASK: rdata_c = {29'h0000_0000, irq_mask_q};
      default: begin
        for (int i = 0; i < NCHAN; i++) begin
          if (haddr[7:0] == chan_off(`COAAL_OFF_CFG0, i)) begin
            rdata_c = cfg_q[i];
          end
          if (haddr[7:0] == chan_off(`COAAL_OFF_THR0, i)) begin
            rdata_c = thr_q[i];
          end
        end
      end
    endcase
  end

  // Bus pipeline: zero wait states, always OKAY
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_q        <= 1'b0;
      waddr_q     <= 8'h00;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b0;
    end else begin
      wr_q        <= acc & hwrite;
      waddr_q     <= haddr[7:0];
      hrdata_q    <= (acc & ~hwrite) ? rdata_c : 32'h0000_0000;
      hreadyout_q <= 1'b1;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = 1'b0;

  // Configuration registers written in the data phase
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_q     <= coaal_pkg::coaal_ctrl_s'(`COAAL_CTRL_RST);
      limits_q   <= coaal_pkg::coaal_limits_s'(`COAAL_LIMITS_RST);
      flow_thr_q <= `COAAL_FLOW_THR_RST;
      irq_mask_q <= 3'h0;
      cfg_q[0]   <= coaal_pkg::coaal_cfg_s'(`COAAL_CFG_ALARM_RST);
      cfg_q[1]   <= coaal_pkg::coaal_cfg_s'(`COAAL_CFG_GREEN_RST);
      cfg_q[2]   <= coaal_pkg::coaal_cfg_s'(`COAAL_CFG_BLUE_RST);
      cfg_q[3]   <= coaal_pkg::coaal_cfg_s'(`COAAL_CFG_RED_RST);
      thr_q[0]   <= coaal_pkg::coaal_thr_s'(`COAAL_THR_ALARM_RST);
      thr_q[1]   <= coaal_pkg::coaal_thr_s'(`COAAL_THR_LED_RST);
      thr_q[2]   <= coaal_pkg::coaal_thr_s'(`COAAL_THR_LED_RST);
      thr_q[3]   <= coaal_pkg::coaal_thr_s'(`COAAL_THR_RED_RST);
    end else if (wr_q) begin
      case (waddr_q)
        `COAAL_OFF_CTRL: begin
          ctrl_q <= coaal_pkg::coaal_ctrl_s'(hwdata & `COAAL_CTRL_WMASK);
        end
        `COAAL_OFF_LIMITS: begin
          limits_q <= coaal_pkg::coaal_limits_s'(hwdata);
        end
        `COAAL_OFF_FLOW_THR: begin
          flow_thr_q <= hwdata[15:0];
        end
        `COAAL_OFF_IRQ_MASK: begin
          irq_mask_q <= hwdata[2:0];
        end
        default: begin
          for (int i = 0; i < NCHAN; i++) begin
            if (waddr_q == chan_off(`COAAL_OFF_CFG0, i)) begin
              cfg_q[i] <= coaal_pkg::coaal_cfg_s'(hwdata & `COAAL_CFG_WMASK);
            end
            if (waddr_q == chan_off(`COAAL_OFF_THR0, i)) begin
              thr_q[i] <= coaal_pkg::coaal_thr_s'(hwdata);
            end
          end
        end
      endcase
    end
  end

  // Three-stage synchroniser; accept once stages two and three agree
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
      pin_s3_q <= 5'h00;
      pin_q    <= 5'h00;
    end else begin
      pin_s1_q <= {alarm_pin_i, digital_inputs_one_to_four};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (pin_s2_q == pin_s3_q) begin
        pin_q <= pin_s3_q;
      end
    end
  end

  // Source selection and scaling
  always_comb begin
    case (ctrl_q.src)
      coaal_pkg::COAAL_SRC_ABS:  src_value = meas.abs_press;
      coaal_pkg::COAAL_SRC_DIFF: src_value = meas.diff_press;
      default:                   src_value = meas.gas;
    endcase
  end

  assign live_level = scale(src_value, limits_q.low, limits_q.high);

  // Fault and phase decode
  assign flow_fault = ctrl_q.flow_en & (meas.diff_press < flow_thr_q);
  assign fault      = sensor_error | flow_fault;
  assign fb_phase   = work_phase[PH_STANDBY] | work_phase[PH_WARMUP]
                    | work_phase[PH_VENT];
  assign keep_vent  = work_phase[PH_VENT]
                    & ((ctrl_q.fallback == coaal_pkg::COAAL_FB_CONT)
                    | (ctrl_q.fallback == coaal_pkg::COAAL_FB_LATCH));

  // Hold the last value seen during measurement
  always_ff @(posedge clock) begin
    if (reset) begin
      latch_q <= `COAAL_LVL_MIN;
    end else if (work_phase[PH_MEASURE]) begin
      latch_q <= live_level;
    end
  end

  // Output level selection, test first, then faults and phases
  always_comb begin
    level_d = live_level;
    if (ctrl_q.test) begin
      level_d = `COAAL_LVL_MID;
    end else if (fault || (fb_phase && !keep_vent)) begin
      level_d = fixed_level(ctrl_q.fallback, fault);
    end else if (keep_vent && ctrl_q.fallback == coaal_pkg::COAAL_FB_LATCH) begin
      level_d = latch_q;
    end
  end

  // Registered loop level
  always_ff @(posedge clock) begin
    if (reset) begin
      level_q <= `COAAL_LVL_MIN;
    end else begin
      level_q <= level_d;
    end
  end

  assign loop_current_level = level_q;

  // Alarm channel and three LED channels
  for (genvar g = 0; g < NCHAN; g++) begin : g_chan
    coaal_chan u_chan (
      .clock    (clock),
      .reset    (reset),
      .cfg      (cfg_q[g]),
      .thr      (thr_q[g]),
      .level    (level_q),
      .inputs   (pin_q[3:0]),
      .phases   (work_phase),
      .active_q (chan_state[g])
    );
  end

  // Registered pin and LED drives
  always_ff @(posedge clock) begin
    if (reset) begin
      alarm_prev_q   <= 1'b0;
      alarm_pin_oe_n <= 1'b1;
      led_q          <= 4'h0;
    end else begin
      alarm_prev_q   <= chan_state[0];
      alarm_pin_oe_n <= ~chan_state[0]; // Sink the pin while the alarm is on
      led_q          <= chan_state;
    end
  end

  assign alarm_pin_o    = 1'b0;
  assign led_green      = led_q[1];
  assign led_blue       = led_q[2];
  assign led_red        = led_q[3];

  // Rising-edge events: alarm, flow fault, sensor error
  always_ff @(posedge clock) begin
    if (reset) begin
      flow_prev_q <= 1'b0;
      err_prev_q  <= 1'b0;
    end else begin
      flow_prev_q <= flow_fault;
      err_prev_q  <= sensor_error;
    end
  end

  assign events = {sensor_error & ~err_prev_q,
                   flow_fault & ~flow_prev_q,
                   chan_state[0] & ~alarm_prev_q};

  // Sticky status, write one to clear, set wins
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (wr_q && waddr_q == `COAAL_OFF_IRQ_STAT) begin
      irq_stat_d = irq_stat_q & ~(hwdata[2:0] & `COAAL_IRQ_WMASK);
    end
    irq_stat_d = irq_stat_d | events;
  end

  // Status and interrupt line
  always_ff @(posedge clock) begin
    if (reset) begin
      irq_stat_q <= 3'h0;
      irq        <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq        <= |(irq_stat_d & irq_mask_q);
    end
  end

endmodule

// *** verification/coaal_assertions.sv ***
// Port checks for the loop output and alarm block
module coaal_assertions (
  // System
  input wire logic                   clock,
  input wire logic                   reset,
  // Bus
  input wire logic                   hsel,
  input wire logic [31:0]            haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic                   hready,
  input wire logic [31:0]            hwdata,
  input wire logic                   hreadyout,
  // Sources and outputs
  input wire coaal_pkg::coaal_meas_s meas,
  input wire logic                   sensor_error,
  input wire logic [5:0]             work_phase,
  input wire logic                   alarm_pin_o,
  input wire logic [15:0]            loop_current_level,
  input wire logic                   led_green,
  input wire logic                   led_blue,
  input wire logic                   led_red
);
  logic       wr_q;
  logic [6:0] ctrl_q;
  logic       fault;
  // Fault as the output path sees it: error, or low flow when enabled
  assign fault = sensor_error | (ctrl_q[6] & (meas.diff_press < 16'h0100));
  // Shadow of the control register, taken from bus writes
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_q   <= 1'b0;
      ctrl_q <= 7'h08;
    end else begin
      wr_q <= hsel & hready & htrans[1] & hwrite & (haddr[7:0] == 8'h00);
      if (wr_q) begin
        ctrl_q <= hwdata[6:0];
      end
    end
  end
  // Fixed level for a fault under each fallback choice
  function automatic logic [15:0] fault_level(input logic [2:0] fb);
    case (fb)
      3'h0:    fault_level = 16'h4E20;
      3'h1:    fault_level = 16'h0FA0;
      default: fault_level = 16'h07D0;
    endcase
  endfunction
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Fault with test off, seen on two successive edges
  sequence s_fault_held;
    (fault && !ctrl_q[2]) [*2];
  endsequence
  a_test_mid_level: assert property (ctrl_q[2] |=> loop_current_level == 16'h2710)
    else $error("test does not give mid level");
  a_fault_fixed_level: assert property (
    s_fault_held |=> loop_current_level == fault_level($past(ctrl_q[5:3])))
    else $error("fault does not give chosen level");
  a_level_in_range: assert property (loop_current_level == 16'h07D0 ||
    (loop_current_level >= 16'h0FA0 && loop_current_level <= 16'h4E20))
    else $error("loop level out of range");
  a_green_all_phases: assert property (
    !$past(reset, 3) |-> led_green == ($past(work_phase, 2) != 6'h00))
    else $error("green does not follow phases");
  a_blue_vent_phases: assert property (
    !$past(reset, 3) |-> led_blue == (($past(work_phase, 2) & 6'h1C) != 6'h00))
    else $error("blue does not follow its phases");
  a_red_set_above: assert property (
    $rose(led_red) |-> $past(loop_current_level, 2) > 16'h3E80)
    else $error("red set below upper threshold");
  a_red_clear_below: assert property (
    $fell(led_red) |-> $past(loop_current_level, 2) < 16'h3A98)
    else $error("red cleared above lower threshold");
  a_bus_zero_wait: assert property (!reset |=> hreadyout)
    else $error("slave inserted a wait state");
  a_drain_low_only: assert property (alarm_pin_o == 1'b0)
    else $error("alarm pin driven high");
endmodule

// *** verification/coaal_loop_rx.sv ***
// Loop receiver and alarm device on the far side of the output pins
module coaal_loop_rx (
  // Block pins
  input  wire logic [15:0] loop_current_level,
  input  wire logic        alarm_pin_o,
  input  wire logic        alarm_pin_oe_n,
  // Observed state
  output logic             pin_level,
  output logic             alarm_on,
  output logic [15:0]      loop_ua
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-up holds the line high unless the block sinks it
  assign pin_level = alarm_pin_oe_n ? 1'b1 : alarm_pin_o;
  // A low line energises the alarm; receiver reads microamps
  assign alarm_on = !pin_level;
  assign loop_ua = loop_current_level;
endmodule

// *** verification/coaal_top_test.sv ***
// Self-checking bench for the loop output and alarm block
`include "coaal_map.svh"
module coaal_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clock, reset, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]           haddr, hwdata, hrdata;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  coaal_pkg::coaal_meas_s meas;
  logic [5:0]            work_phase;
  logic [3:0]            digital_inputs_one_to_four;
  logic                  sensor_error, alarm_pin_i, alarm_pin_o, alarm_pin_oe_n, irq;
  logic                  led_green, led_blue, led_red, alarm_on;
  logic [15:0]           loop_current_level, loop_ua;
  int                    failures = 0;
  int                    num_checks = 0;
  assign hready = hreadyout;
  // Block and its far side
  coaal_top i_coaal_top (.clock, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
    .hwdata, .hrdata, .hreadyout, .hresp, .meas, .sensor_error, .work_phase,
    .digital_inputs_one_to_four, .alarm_pin_i, .alarm_pin_o, .alarm_pin_oe_n,
    .loop_current_level, .led_green, .led_blue, .led_red, .irq);
  coaal_loop_rx i_coaal_loop_rx (.loop_current_level, .alarm_pin_o, .alarm_pin_oe_n,
    .pin_level(alarm_pin_i), .alarm_on, .loop_ua);
  // Clock at 50 ns period
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic finish_test;
    $display("Checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge clock); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do @(posedge clock); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  // Output and pin checks after the pipeline has settled
  task automatic lvl(input logic [15:0] e);
    repeat (3) @(posedge clock);
    chk({16'h0, loop_ua}, {16'h0, e});
  endtask
  task automatic al(input logic e);
    repeat (8) @(posedge clock);
    chk({28'h0, alarm_on, led_green, led_blue, led_red}, {28'h0, e, 1'b1, 1'b0, 1'b0});
  endtask
  task automatic t_regs;
    logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h28};
    logic [31:0] rv [8] = '{32'h0000_0008, 32'hFFFF_0000, 32'h0000_0100, 32'h0000_0000,
                            32'h0000_07E5, 32'h0000_0385, 32'h0000_0001, 32'h3E80_3A98};
    for (int i = 0; i < 8; i++) begin
      rchk(ra[i], rv[i]);
    end
    wr(`COAAL_OFF_CTRL, 32'hFFFF_FFFF);
    rchk(`COAAL_OFF_CTRL, 32'h0000_007F);
    wr(`COAAL_OFF_CTRL, 32'h0000_0008);
    wr(8'h40, 32'hFFFF_FFFF);
    rchk(8'h40, 32'h0000_0000);
    $display("Register test done");
  endtask
  task automatic t_scale;
    wr(`COAAL_OFF_LIMITS, 32'h07D0_03E8);
    meas <= {16'h05DC, 16'h04E2, 16'h09C4};
    lvl(16'h2EE0);
    wr(`COAAL_OFF_CTRL, 32'h0000_0009);
    lvl(16'h1F40);
    wr(`COAAL_OFF_CTRL, 32'h0000_000A);
    lvl(16'h4E20);
    wr(`COAAL_OFF_CTRL, 32'h0000_0008);
    meas.gas <= 16'h01F4;
    lvl(16'h0FA0);
    meas.gas <= 16'h07D0;
    lvl(16'h4E20);
    $display("Scaling test done");
  endtask
  task automatic t_fallback;
    logic [15:0] fl [3] = '{16'h4E20, 16'h0FA0, 16'h07D0};
    logic [5:0]  ph [3] = '{6'h01, 6'h02, 6'h04};
    meas.gas <= 16'h05DC;
    for (int p = 0; p < 3; p++) begin
      for (int f = 0; f < 3; f++) begin
        work_phase <= ph[p];
        wr(`COAAL_OFF_CTRL, 32'(f * 8));
        lvl(fl[f]);
      end
    end
    work_phase <= 6'h20;
    sensor_error <= 1'b1;
    lvl(16'h07D0);
    sensor_error <= 1'b0;
    wr(`COAAL_OFF_CTRL, 32'h0000_0048);
    meas.diff_press <= 16'h00FF;
    lvl(16'h0FA0);
    meas.diff_press <= 16'h0100;
    lvl(16'h2EE0);
    wr(`COAAL_OFF_CTRL, 32'h0000_0004);
    sensor_error <= 1'b1;
    lvl(16'h2710);
    sensor_error <= 1'b0;
    wr(`COAAL_OFF_CTRL, 32'h0000_0020);
    work_phase <= 6'h04;
    meas.gas <= 16'h04E2;
    lvl(16'h2EE0);
    wr(`COAAL_OFF_CTRL, 32'h0000_0018);
    lvl(16'h1F40);
    wr(`COAAL_OFF_CTRL, 32'h0000_0008);
    work_phase <= 6'h20;
    $display("Fallback test done");
  endtask
  task automatic t_alarm;
    wr(`COAAL_OFF_CFG0, 32'h1);
    meas.gas <= 16'h0640;
    al(1'b0);
    meas.gas <= 16'h0659;
    al(1'b1);
    meas.gas <= 16'h05DC;
    al(1'b1);
    meas.gas <= 16'h04E2;
    al(1'b0);
    wr(`COAAL_OFF_CFG0, 32'h2);
    al(1'b1);
    meas.gas <= 16'h0659;
    al(1'b0);
    for (int s = 0; s < 8; s++) begin
      wr(`COAAL_OFF_CFG0, 32'h3 + 32'(s / 4) + 32'((s % 4) * 8));
      digital_inputs_one_to_four <= 4'h1 << (s % 4);
      al(s < 4);
      digital_inputs_one_to_four <= 4'hF ^ (4'h1 << (s % 4));
      al(s >= 4);
    end
    wr(`COAAL_OFF_CFG0, 32'h85);
    work_phase <= 6'h04;
    repeat (8) @(posedge clock);
    chk({30'h0, alarm_on, led_blue}, 32'h3);
    work_phase <= 6'h20;
    meas.gas <= 16'h0708;
    repeat (8) @(posedge clock);
    chk({29'h0, alarm_on, led_green, led_red}, 32'h3);
    $display("Alarm test done");
  endtask
  task automatic t_irq;
    wr(`COAAL_OFF_CFG0, 32'h1);
    meas.gas <= 16'h04E2;
    wr(`COAAL_OFF_IRQ_MASK, 32'h0);
    wr(`COAAL_OFF_IRQ_STAT, 32'h7);
    meas.gas <= 16'h0659;
    al(1'b1);
    chk({31'h0, irq}, 32'h0);
    rchk(`COAAL_OFF_IRQ_STAT, 32'h1);
    wr(`COAAL_OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    wr(`COAAL_OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    rchk(`COAAL_OFF_IRQ_STAT, 32'h0);
    rchk(`COAAL_OFF_STATUS, 32'h3A03_36B0);
    $display("Interrupt test done");
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (10000) @(posedge clock);
    failures++;
    $display("Error at %0t ns: watchdog expired", $time);
    finish_test;
  end
  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    meas = '0;
    sensor_error = 1'b0;
    work_phase = 6'h20;
    digital_inputs_one_to_four = 4'h0;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    t_regs;
    t_scale;
    t_fallback;
    t_alarm;
    t_irq;
    finish_test;
  end
endmodule
bind coaal_top coaal_assertions i_coaal_assertions (.clock, .reset, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hwdata, .hreadyout, .meas, .sensor_error, .work_phase, .alarm_pin_o,
  .loop_current_level, .led_green, .led_blue, .led_red);
